// >>> bidir_latch_reg_bus_transceiver_tb_top.sv
// Self-checking bench for the two-way storing bus transceiver
module bidir_latch_reg_bus_transceiver_tb_top import transceiver_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic dir;
        logic en;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] exp_oe;
    } row_t;
    localparam logic [DATA_W-1:0] ONES = 36'hF_FFFF_FFFF;
    localparam logic [DATA_W-1:0] ZERO = 36'h0_0000_0000;
    localparam row_t ROWS [4] = '{
        '{1'b0, 1'b1, 36'hA_5A5A_5A5A, ONES},
        '{1'b0, 1'b0, 36'h5_A5A5_A5A5, ZERO},
        '{1'b1, 1'b1, 36'hF_FFFF_FFFF, ONES},
        '{1'b1, 1'b0, 36'h0_1234_5678, ZERO}
    };
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [DATA_W-1:0] a_data_in, a_data_out, a_oe_out, b_data_in, b_data_out, b_oe_out;
    logic [DATA_W-1:0] ext_a = ZERO;
    logic [DATA_W-1:0] ext_b = ZERO;
    logic ab_en = 1'b0;
    logic ba_en_n = 1'b1;
    logic ab_tr = 1'b0;
    logic ba_tr = 1'b0;
    logic ab_clk = 1'b0;
    logic ba_clk = 1'b0;
    logic [REG_AW-1:0] reg_addr_in = 8'h00;
    logic [REG_DW-1:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [REG_DW-1:0] reg_rdata_out, rd, hi;
    logic log_ready_out;
    int failures = 0;
    int checks_done = 0;

    bus_transceiver_top dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .a_data_in(a_data_in), .a_data_out(a_data_out), .a_oe_out(a_oe_out),
        .b_data_in(b_data_in), .b_data_out(b_data_out), .b_oe_out(b_oe_out),
        .a_to_b_drive_enable_in(ab_en), .b_to_a_drive_enable_n_in(ba_en_n),
        .a_to_b_transparent_ctl_in(ab_tr), .b_to_a_transparent_ctl_in(ba_tr),
        .a_to_b_capture_clock_in(ab_clk), .b_to_a_capture_clock_in(ba_clk),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .log_ready_out(log_ready_out)
    );
    port_bus_model side_a (.clk_in(clk_in), .dev_data_in(a_data_out), .dev_oe_in(a_oe_out),
        .ext_en_in(1'b1), .ext_data_in(ext_a), .level_out(a_data_in));
    port_bus_model side_b (.clk_in(clk_in), .dev_data_in(b_data_out), .dev_oe_in(b_oe_out),
        .ext_en_in(1'b1), .ext_data_in(ext_b), .level_out(b_data_in));

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        @(posedge clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask
    task automatic reg_chk(input string name, input logic [REG_AW-1:0] a,
        input logic [REG_DW-1:0] e);
        reg_rd(a, rd);
        check(name, {4'h0, rd}, {4'h0, e});
    endtask
    // One rising capture edge, clock back low afterwards
    task automatic capture(input logic dir);
        @(posedge clk_in);
        ab_clk <= ~dir;
        ba_clk <= dir;
        repeat (2) @(posedge clk_in);
        ab_clk <= 1'b0;
        ba_clk <= 1'b0;
        step(3);
    endtask
    function automatic logic [DATA_W-1:0] entry(input int i);
        return {i[3:0], 32'hA500_0000 | i[31:0]};
    endfunction
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        check("b_oe reset", b_oe_out, ZERO);
        check("a_oe reset", a_oe_out, ZERO);
        check("b_data reset", b_data_out, ZERO);
        check("log_ready reset", {35'h0, log_ready_out}, 36'h1);
        reg_chk("ctrl reset", CTRL_OFS, 32'h0);
        reg_chk("status reset", STATUS_OFS, 32'h0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            @(posedge clk_in);
            ab_tr <= ~ROWS[i].dir;
            ba_tr <= ROWS[i].dir;
            ab_en <= ~ROWS[i].dir & ROWS[i].en;
            ba_en_n <= ~(ROWS[i].dir & ROWS[i].en);
            if (ROWS[i].dir) begin
                ext_b <= ROWS[i].d;
            end else begin
                ext_a <= ROWS[i].d;
            end
            step(5);
            if (ROWS[i].dir) begin
                check("a_data", a_data_out, ROWS[i].d);
                check("a_oe", a_oe_out, ROWS[i].exp_oe);
                check("b_oe", b_oe_out, ZERO);
            end else begin
                check("b_data", b_data_out, ROWS[i].d);
                check("b_oe", b_oe_out, ROWS[i].exp_oe);
                check("a_oe", a_oe_out, ZERO);
            end
        end
        $display("test rows done");
        @(posedge clk_in);
        ba_tr <= 1'b0;
        ab_en <= 1'b1;
        ba_en_n <= 1'b1;
        ext_a <= 36'h9_8765_4321;
        step(5);
        check("b_data clock low", b_data_out, 36'h5_A5A5_A5A5);
        capture(1'b0);
        check("b_data capture", b_data_out, 36'h9_8765_4321);
        @(posedge clk_in);
        ext_a <= 36'h3_3333_3333;
        step(5);
        check("b_data held low", b_data_out, 36'h9_8765_4321);
        @(posedge clk_in);
        ab_clk <= 1'b1;
        step(5);
        check("b_data rise", b_data_out, 36'h3_3333_3333);
        @(posedge clk_in);
        ext_a <= 36'hE_EEEE_EEEE;
        step(5);
        check("b_data held high", b_data_out, 36'h3_3333_3333);
        @(posedge clk_in);
        ab_clk <= 1'b0;
        reg_chk("ab lo", AB_LO_OFS, 32'h3333_3333);
        reg_chk("ab hi", AB_HI_OFS, 32'h3);
        $display("test a_to_b capture done");
        @(posedge clk_in);
        ext_b <= 36'hC_0FFE_E000;
        ab_en <= 1'b0;
        ba_en_n <= 1'b0;
        step(3);
        capture(1'b1);
        check("a_data capture", a_data_out, 36'hC_0FFE_E000);
        check("a_oe on", a_oe_out, ONES);
        reg_chk("ba lo", BA_LO_OFS, 32'h0FFE_E000);
        $display("test b_to_a capture done");
        @(posedge clk_in);
        ab_tr <= 1'b1;
        ab_en <= 1'b1;
        ba_en_n <= 1'b1;
        step(5);
        @(posedge clk_in);
        ext_a <= 36'h7_0000_0007;
        step(2);
        check("b_data before", b_data_out, 36'hE_EEEE_EEEE);
        step(1);
        check("b_data after", b_data_out, 36'h7_0000_0007);
        reg_wr(CTRL_OFS, 32'h2);
        step(2);
        check("b_oe hiz", b_oe_out, ZERO);
        check("a_oe hiz", a_oe_out, ZERO);
        reg_wr(CTRL_OFS, 32'h1);
        step(3);
        check("b_oe back", b_oe_out, ONES);
        $display("test latency and float done");
        @(posedge clk_in);
        ab_tr <= 1'b0;
        for (int i = 0; i < 33; i++) begin
            @(posedge clk_in);
            ext_a <= entry(i);
            step(2);
            capture(1'b0);
        end
        check("log_ready full", {35'h0, log_ready_out}, ZERO);
        reg_chk("status full", STATUS_OFS, 32'h1D);
        for (int i = 0; i < 32; i++) begin
            reg_rd(LOG_HI_OFS, hi);
            reg_rd(LOG_LO_OFS, rd);
            check("log entry", {hi[3:0], rd}, entry(i));
        end
        step(1);
        check("rdata idle", {4'h0, reg_rdata_out}, ZERO);
        reg_chk("status drained", STATUS_OFS, 32'h11);
        reg_chk("log empty", LOG_LO_OFS, 32'h0);
        reg_wr(STATUS_OFS, 32'h10);
        reg_chk("status cleared", STATUS_OFS, 32'h01);
        reg_chk("ab count", AB_CNT_OFS, 32'h23);
        reg_chk("ba count", BA_CNT_OFS, 32'h1);
        reg_chk("unmapped", 8'h30, 32'h0);
        $display("test log and registers done");
        results();
    end
endmodule // bidir_latch_reg_bus_transceiver_tb_top

// >>> bus_transceiver_top.sv
// Constants and top level of the two-way storing bus transceiver
//
// Chosen here: the placing of the registers and the address-and-strobe port.
package transceiver_pkg;
    localparam int DATA_W = 36;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int HI_W = DATA_W - REG_DW;
    localparam int LOG_DEPTH = 32;
    // Register byte offsets
    localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
    localparam logic [REG_AW-1:0] STATUS_OFS = 8'h04;
    localparam logic [REG_AW-1:0] AB_LO_OFS = 8'h08;
    localparam logic [REG_AW-1:0] AB_HI_OFS = 8'h0C;
    localparam logic [REG_AW-1:0] BA_LO_OFS = 8'h10;
    localparam logic [REG_AW-1:0] BA_HI_OFS = 8'h14;
    localparam logic [REG_AW-1:0] LOG_LO_OFS = 8'h18;
    localparam logic [REG_AW-1:0] LOG_HI_OFS = 8'h1C;
    localparam logic [REG_AW-1:0] AB_CNT_OFS = 8'h20;
    localparam logic [REG_AW-1:0] BA_CNT_OFS = 8'h24;
    // Control fields
    localparam int CTRL_LOG_EN_BIT = 0;
    localparam int CTRL_HIZ_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    // Status fields
    localparam int ST_AB_DRV_BIT = 0;
    localparam int ST_BA_DRV_BIT = 1;
    localparam int ST_LOG_AVAIL_BIT = 2;
    localparam int ST_LOG_FULL_BIT = 3;
    localparam int ST_OVF_BIT = 4;
    localparam int ST_W = 5;
endpackage

import transceiver_pkg::*;

module bus_transceiver_top
    import transceiver_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = LOG_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Port A pins
    input wire logic [WIDTH-1:0] a_data_in,
    output logic [WIDTH-1:0] a_data_out,
    output logic [WIDTH-1:0] a_oe_out,
    // Port B pins
    input wire logic [WIDTH-1:0] b_data_in,
    output logic [WIDTH-1:0] b_data_out,
    output logic [WIDTH-1:0] b_oe_out,
    // Direction control pins
    input wire logic a_to_b_drive_enable_in,
    input wire logic b_to_a_drive_enable_n_in,
    input wire logic a_to_b_transparent_ctl_in,
    input wire logic b_to_a_transparent_ctl_in,
    input wire logic a_to_b_capture_clock_in,
    input wire logic b_to_a_capture_clock_in,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr_in,
    input wire logic [REG_DW-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [REG_DW-1:0] reg_rdata_out,
    // Capture log back-pressure
    output logic log_ready_out
);
    generate
        if (WIDTH <= REG_DW || WIDTH > 2 * REG_DW) begin : g_bad
            $error("bus_transceiver_top: WIDTH must be 33 to 64");
        end
    endgenerate

    localparam int WHI = WIDTH - REG_DW;

    default clocking main_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Stored values and capture pulses of both directions
    logic [WIDTH-1:0] ab_stored;
    logic [WIDTH-1:0] ba_stored;
    logic ab_capture;
    logic ba_capture;

    // Enable pin synchronisers
    logic [1:0] en_s1_reg;
    logic [1:0] en_s2_reg;

    // Software state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic overflow_reg;
    logic overflow_next;
    logic [REG_DW-1:0] ab_cnt_reg;
    logic [REG_DW-1:0] ba_cnt_reg;
    logic [REG_DW-1:0] rdata_reg;
    logic [REG_DW-1:0] rdata_next;

    // Capture log FIFO
    logic log_in_valid;
    logic log_in_ready;
    logic log_out_valid;
    logic log_pop;
    logic [WIDTH-1:0] log_data;

    xfer_path #(
        .WIDTH(WIDTH)
    ) u_ab_path (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .data_in(a_data_in),
        .transparent_in(a_to_b_transparent_ctl_in),
        .capture_clk_in(a_to_b_capture_clock_in),
        .stored_out(ab_stored),
        .capture_out(ab_capture)
    );

    xfer_path #(
        .WIDTH(WIDTH)
    ) u_ba_path (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .data_in(b_data_in),
        .transparent_in(b_to_a_transparent_ctl_in),
        .capture_clk_in(b_to_a_capture_clock_in),
        .stored_out(ba_stored),
        .capture_out(ba_capture)
    );

    xfer_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_log (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(log_in_valid),
        .in_ready_out(log_in_ready),
        .in_data_in(ab_stored),
        .out_valid_out(log_out_valid),
        .out_ready_in(log_pop),
        .out_data_out(log_data)
    );

    // Enable pins pass two flops before use
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_s1_reg <= 2'h0;
            en_s2_reg <= 2'h0;
        end else begin
            en_s1_reg <= {!b_to_a_drive_enable_n_in, a_to_b_drive_enable_in};
            en_s2_reg <= en_s1_reg;
        end
    end

    // Output drive; software can float both ports
    logic ab_drive;
    logic ba_drive;
    assign ab_drive = en_s2_reg[0] && !ctrl_reg[CTRL_HIZ_BIT];
    assign ba_drive = en_s2_reg[1] && !ctrl_reg[CTRL_HIZ_BIT];
    assign b_oe_out = {WIDTH{ab_drive}};
    assign a_oe_out = {WIDTH{ba_drive}};
    assign b_data_out = ab_stored;
    assign a_data_out = ba_stored;

    // Register decode
    logic wr_ctrl;
    logic wr_status;
    logic rd_log_lo;
    assign wr_ctrl = reg_write_in && (reg_addr_in == CTRL_OFS);
    assign wr_status = reg_write_in && (reg_addr_in == STATUS_OFS);
    assign rd_log_lo = reg_read_in && (reg_addr_in == LOG_LO_OFS);

    // Log: A-to-B clocked captures enter while enabled; reading the low word pops
    assign log_in_valid = ab_capture && ctrl_reg[CTRL_LOG_EN_BIT];
    assign log_pop = rd_log_lo && log_out_valid;
    assign log_ready_out = log_in_ready;

    assign ctrl_next = wr_ctrl ? reg_wdata_in[CTRL_W-1:0] : ctrl_reg;

    // Lost capture sets overflow; the set beats a clear in the same cycle
    logic ovf_set;
    logic ovf_clr;
    assign ovf_set = log_in_valid && !log_in_ready;
    assign ovf_clr = wr_status && reg_wdata_in[ST_OVF_BIT];
    assign overflow_next = ovf_set || (overflow_reg && !ovf_clr);

    // Read view
    logic [ST_W-1:0] status_view;
    assign status_view = {overflow_reg, !log_in_ready, log_out_valid, ba_drive, ab_drive};

    logic [REG_DW-1:0] hi_ab;
    logic [REG_DW-1:0] hi_ba;
    logic [REG_DW-1:0] hi_log;
    logic [REG_DW-1:0] lo_log;
    assign hi_ab = {{(REG_DW - WHI){1'b0}}, ab_stored[WIDTH-1:REG_DW]};
    assign hi_ba = {{(REG_DW - WHI){1'b0}}, ba_stored[WIDTH-1:REG_DW]};
    assign hi_log = log_out_valid ? {{(REG_DW - WHI){1'b0}}, log_data[WIDTH-1:REG_DW]} : '0;
    assign lo_log = log_out_valid ? log_data[REG_DW-1:0] : '0;

    logic [REG_DW-1:0] rd_mux;
    always_comb begin
        case (reg_addr_in)
            CTRL_OFS: rd_mux = {{(REG_DW - CTRL_W){1'b0}}, ctrl_reg};
            STATUS_OFS: rd_mux = {{(REG_DW - ST_W){1'b0}}, status_view};
            AB_LO_OFS: rd_mux = ab_stored[REG_DW-1:0];
            AB_HI_OFS: rd_mux = hi_ab;
            BA_LO_OFS: rd_mux = ba_stored[REG_DW-1:0];
            BA_HI_OFS: rd_mux = hi_ba;
            LOG_LO_OFS: rd_mux = lo_log;
            LOG_HI_OFS: rd_mux = hi_log;
            AB_CNT_OFS: rd_mux = ab_cnt_reg;
            BA_CNT_OFS: rd_mux = ba_cnt_reg;
            default: rd_mux = '0;
        endcase
    end
    assign rdata_next = reg_read_in ? rd_mux : '0;
    assign reg_rdata_out = rdata_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= CTRL_RESET;
            overflow_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            overflow_reg <= overflow_next;
            rdata_reg <= rdata_next;
        end
    end

    // Free-running capture counters, wrap at the top
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ab_cnt_reg <= '0;
            ba_cnt_reg <= '0;
        end else begin
            ab_cnt_reg <= ab_cnt_reg + REG_DW'(ab_capture);
            ba_cnt_reg <= ba_cnt_reg + REG_DW'(ba_capture);
        end
    end

    // Checks on drive enables, transparent paths, register port and log
    b_drive_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        b_oe_out[0] |-> $past(a_to_b_drive_enable_in, 2))
        else $error("Port B driven without A-to-B enable");
    b_float_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !$past(a_to_b_drive_enable_in, 2) |-> b_oe_out == '0)
        else $error("Port B not floated with enable low");
    a_drive_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        a_oe_out[0] |-> !$past(b_to_a_drive_enable_n_in, 2))
        else $error("Port A driven with B-to-A enable high");
    a_float_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(b_to_a_drive_enable_n_in, 2) |-> a_oe_out == '0)
        else $error("Port A not floated with enable high");
    ab_pass_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        a_to_b_transparent_ctl_in [*4] |-> b_data_out == $past(a_data_in, 3))
        else $error("Port B does not follow port A when transparent");
    ba_pass_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        b_to_a_transparent_ctl_in [*4] |-> a_data_out == $past(b_data_in, 3))
        else $error("Port A does not follow port B when transparent");
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !$past(reg_read_in) |-> reg_rdata_out == '0)
        else $error("Read data not zero outside read answer");
    ovf_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        log_in_valid && !log_in_ready |=> overflow_reg)
        else $error("Lost capture did not set overflow");

    // Drive enables
    hiz_float_a: assert property (
        ctrl_reg[CTRL_HIZ_BIT] |-> b_oe_out == '0 && a_oe_out == '0)
        else $error("Port driven while floated by software");
    b_oe_same_a: assert property (
        b_oe_out == {WIDTH{b_oe_out[0]}})
        else $error("Port B enables differ");
    a_oe_same_a: assert property (
        a_oe_out == {WIDTH{a_oe_out[0]}})
        else $error("Port A enables differ");

    // Register port
    rdata_ans_a: assert property (
        reg_read_in |=> reg_rdata_out == $past(rd_mux))
        else $error("Read answer wrong");
    ctrl_wr_a: assert property (
        wr_ctrl |=> ctrl_reg == $past(reg_wdata_in[CTRL_W-1:0]))
        else $error("Control write lost");
    ctrl_keep_a: assert property (
        !wr_ctrl |=> $stable(ctrl_reg))
        else $error("Control changed without write");
    status_ovf_a: assert property (
        reg_read_in && reg_addr_in == STATUS_OFS |=>
        reg_rdata_out[ST_OVF_BIT] == $past(overflow_reg))
        else $error("Status overflow bit wrong");
    unmapped_rd_a: assert property (
        reg_read_in && reg_addr_in > BA_CNT_OFS |=> reg_rdata_out == '0)
        else $error("Unmapped read not zero");
    hi_zero_a: assert property (
        reg_read_in && reg_addr_in == AB_HI_OFS |=> reg_rdata_out[REG_DW-1:WHI] == '0)
        else $error("Reserved high bits not zero");

    // Overflow flag
    ovf_clr_a: assert property (
        overflow_reg && ovf_clr && !ovf_set |=> !overflow_reg)
        else $error("Overflow not cleared");
    ovf_keep_a: assert property (
        overflow_reg && !ovf_clr |=> overflow_reg)
        else $error("Overflow lost");
    ovf_idle_a: assert property (
        !overflow_reg && !ovf_set |=> !overflow_reg)
        else $error("Overflow set without loss");

    // Log
    log_push_a: assert property (
        log_in_valid && log_in_ready |=> log_out_valid)
        else $error("Pushed capture not in log");
    full_stays_a: assert property (
        !log_in_ready && !log_pop |=> !log_in_ready)
        else $error("Full log left full without pop");
    log_rd_a: assert property (
        log_pop |=> reg_rdata_out == $past(log_data[REG_DW-1:0]))
        else $error("Log low word wrong");
    log_empty_a: assert property (
        rd_log_lo && !log_out_valid |=> reg_rdata_out == '0)
        else $error("Empty log read not zero");

    // Capture counters
    ab_cnt_a: assert property (
        ab_capture |=> ab_cnt_reg == $past(ab_cnt_reg) + 32'h1)
        else $error("A-to-B count missed a capture");
    ab_cnt_keep_a: assert property (
        !ab_capture |=> $stable(ab_cnt_reg))
        else $error("A-to-B count moved");
    ba_cnt_a: assert property (
        ba_capture |=> ba_cnt_reg == $past(ba_cnt_reg) + 32'h1)
        else $error("B-to-A count missed a capture");
    ba_cnt_keep_a: assert property (
        !ba_capture |=> $stable(ba_cnt_reg))
        else $error("B-to-A count moved");

    transp_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        a_to_b_transparent_ctl_in [*4] ##1 b_oe_out[0]);
    log_full_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !log_in_ready);
    ovf_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        ovf_set ##1 ovf_clr);
    pop_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        log_pop);
endmodule // bus_transceiver_top

// >>> port_bus_model.sv
// Far-side bus party for one transceiver port
module port_bus_model #(
    parameter int WIDTH = 36
) (
    // Clock
    input wire logic clk_in,
    // Device side of the pin
    input wire logic [WIDTH-1:0] dev_data_in,
    input wire logic [WIDTH-1:0] dev_oe_in,
    // Party's own drive
    input wire logic ext_en_in,
    input wire logic [WIDTH-1:0] ext_data_in,
    // Resolved wire level
    output logic [WIDTH-1:0] level_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] party_drv;
    // Party drives only bits the device leaves floating
    assign party_drv = ~dev_oe_in & {WIDTH{ext_en_in}};
    // Undriven bits show the inverse of the last level
    assign level_out = (dev_oe_in & dev_data_in) | (party_drv & ext_data_in)
        | (~dev_oe_in & ~party_drv & ~last_reg);
    always_ff @(posedge clk_in) begin
        last_reg <= level_out;
    end
endmodule // port_bus_model

// >>> xfer_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module xfer_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("xfer_fifo: DEPTH must be a power of two above 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW:0] wr_ptr_reg;
    logic [PW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;
    assign out_data_out = mem_reg[rd_ptr_reg[PW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg[PW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
        end
    end

    no_push_full_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        full && !pop |=> $stable(wr_ptr_reg))
        else $error("FIFO write pointer moved while full");
endmodule // xfer_fifo

// >>> xfer_path.sv
// One direction of storage: latch or edge capture per bit
module xfer_path #(
    parameter int WIDTH = 36
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Pins of the source port and direction controls
    input wire logic [WIDTH-1:0] data_in,
    input wire logic transparent_in,
    input wire logic capture_clk_in,
    // Stored value and capture pulse
    output logic [WIDTH-1:0] stored_out,
    output logic capture_out
);
    generate
        if (WIDTH < 1 || WIDTH > 64) begin : g_bad
            $error("xfer_path: WIDTH must be 1 to 64");
        end
    endgenerate

    logic [WIDTH-1:0] data_s1_reg;
    logic [WIDTH-1:0] data_s2_reg;
    logic [1:0] ctl_s1_reg;
    logic [1:0] ctl_s2_reg;
    logic clk_prev_reg;
    logic capture_reg;
    logic transp;
    logic clk_lvl;
    logic rise;
    logic load;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_s1_reg <= '0;
            data_s2_reg <= '0;
            ctl_s1_reg <= '0;
            ctl_s2_reg <= '0;
            clk_prev_reg <= 1'b0;
            capture_reg <= 1'b0;
        end else begin
            data_s1_reg <= data_in;
            data_s2_reg <= data_s1_reg;
            ctl_s1_reg <= {capture_clk_in, transparent_in};
            ctl_s2_reg <= ctl_s1_reg;
            clk_prev_reg <= clk_lvl;
            capture_reg <= rise && !transp;
        end
    end

    assign transp = ctl_s2_reg[0];
    assign clk_lvl = ctl_s2_reg[1];
    assign rise = clk_lvl && !clk_prev_reg;
    // Level open passes data; otherwise only a rising capture edge loads
    assign load = transp || rise;
    assign capture_out = capture_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic bit_reg;
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    bit_reg <= 1'b0;
                end else if (load) begin
                    bit_reg <= data_s2_reg[i];
                end
            end
            assign stored_out[i] = bit_reg;
        end
    endgenerate

    transp_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        transp |=> stored_out == $past(data_s2_reg))
        else $error("Transparent path did not follow input");
    latched_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !transp && !rise |=> $stable(stored_out))
        else $error("Stored value changed without capture");
    edge_capture_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !transp && rise |=> stored_out == $past(data_s2_reg) && capture_out)
        else $error("Rising capture edge not stored");
    low_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (!transp && !clk_lvl)[*3] |=> $stable(stored_out) && !capture_out)
        else $error("Held low clock changed output");
    cap_seen_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !transp && rise ##1 capture_out);
endmodule // xfer_path
